// File: shared/zph_pkg.sv
// Contract
// - zone select code 0 off, 1 compares setpoint, 2 compares process value
// - zone hysteresis default 5, each of seven thresholds defaults 9999
// - zone selection and its settings only work under pid fixed control (code 1)
// - zone off: active group is the setpoint bank group
// - zone on: bank group ignored, group follows zone comparisons
// - boundary crossing happens at threshold plus one unit
// - contact input assigned to group selection disables zone selection
// - motor drive relay output keeps heat/cool split unavailable
// - heat/cool settings visible and writable only when heat/cool enabled
// - energy mode suppresses heat/cool switching; no effect with deadband below zero
// - heat = (mv-cp-db/2)*rate, cool = (cp-mv-db/2)*rate
// - rate = 100/(cp - db/2)
// - heat clamped by mv limits, cool clamped by cooling limits
// - heat group when mv at or above 50 percent, else cool group
// - group switch point stays 50 percent whatever the change point
// - low limit above high limit: limits swapped before clamping
// shared constants and types for the zone group and heat/cool split block
// assumes percent values in signed tenths of a percent, zone values in units
package zph_pkg;
	localparam int          ZPH_AW          = 5;
	localparam int          ZPH_DW          = 16;
	localparam int          ZPH_ZONES       = 7;
	localparam logic [4:0]  ZPH_A_CTRL      = 5'h00;
	localparam logic [4:0]  ZPH_A_ZSEL      = 5'h01;
	localparam logic [4:0]  ZPH_A_ZONE0     = 5'h02;
	localparam logic [4:0]  ZPH_A_ZHYS      = 5'h09;
	localparam logic [4:0]  ZPH_A_SPGRP     = 5'h0A;
	localparam logic [4:0]  ZPH_A_HCEN      = 5'h0B;
	localparam logic [4:0]  ZPH_A_HCMODE    = 5'h0C;
	localparam logic [4:0]  ZPH_A_DB        = 5'h0D;
	localparam logic [4:0]  ZPH_A_CP        = 5'h0E;
	localparam logic [4:0]  ZPH_A_MVLO      = 5'h0F;
	localparam logic [4:0]  ZPH_A_MVHI      = 5'h10;
	localparam logic [4:0]  ZPH_A_CLLO      = 5'h11;
	localparam logic [4:0]  ZPH_A_CLHI      = 5'h12;
	localparam logic [4:0]  ZPH_A_STAT      = 5'h13;
	localparam logic [4:0]  ZPH_A_HEATMV    = 5'h14;
	localparam logic [4:0]  ZPH_A_COOLMV    = 5'h15;
	localparam logic [1:0]  ZPH_CTRL_PIDFIX = 2'h1;
	localparam logic [1:0]  ZPH_ZSEL_OFF    = 2'h0;
	localparam logic [1:0]  ZPH_ZSEL_SP     = 2'h1;
	localparam logic [1:0]  ZPH_ZSEL_PV     = 2'h2;
	localparam logic [1:0]  ZPH_RST_CTRL    = 2'h1;
	localparam logic [15:0] ZPH_RST_ZONE    = 16'h270F;
	localparam logic [15:0] ZPH_RST_ZHYS    = 16'h0005;
	localparam logic [15:0] ZPH_RST_DB      = 16'h0000;
	localparam logic [15:0] ZPH_RST_CP      = 16'h01F4;
	localparam logic [15:0] ZPH_RST_LO      = 16'h0000;
	localparam logic [15:0] ZPH_RST_HI      = 16'h03E8;
	localparam logic [15:0] ZPH_MV_HALF     = 16'h01F4;
	localparam logic [31:0] ZPH_PCT_FULL    = 32'h0000_03E8;
	localparam logic [2:0]  ZPH_LAST_GROUP  = 3'h7;
	localparam logic [17:0] ZPH_ONE_UNIT    = 18'h00001;
	typedef struct packed {
		logic signed [15:0] lo;
		logic signed [15:0] hi;
	} zph_lim_t;
	typedef struct packed {
		logic signed [15:0] deadband;
		logic signed [15:0] change_point;
		zph_lim_t           heat_lim;
		zph_lim_t           cool_lim;
	} zph_hc_cfg_t;
endpackage

// File: core/zph_clamp.sv
// clamps a signed value between two limits, swapping them if given reversed
// assumes limits fit in the value width after sign extension
`timescale 1ns/100ps
module zph_clamp
	import zph_pkg::*;
#(
	parameter int W = 32
)
(
	input  wire logic signed [W-1:0] value,
	input  wire zph_lim_t            lim,
	output logic signed [15:0]       result
);
	logic signed [W-1:0] lo_x;
	logic signed [W-1:0] hi_x;
	logic signed [W-1:0] tmp;

	always_comb
	begin
		if (lim.lo > lim.hi)
		begin
			lo_x = W'(lim.hi);
			hi_x = W'(lim.lo);
		end
		else
		begin
			lo_x = W'(lim.lo);
			hi_x = W'(lim.hi);
		end
		if (value < lo_x)
			tmp = lo_x;
		else if (value > hi_x)
			tmp = hi_x;
		else
			tmp = value;
		result = tmp[15:0];
	end
endmodule

// File: core/zph_top.sv
// zone pid group selection and heat/cool output split
// assumes mv, setpoint and process value are synchronous to ref_clk
`timescale 1ns/100ps
module zph_top
	import zph_pkg::*;
(
	input  wire logic                    ref_clk,
	input  wire logic                    rstn,
	input  wire logic [ZPH_AW-1:0]       addr,
	input  wire logic [ZPH_DW-1:0]       wdata,
	input  wire logic                    wr_stb,
	input  wire logic                    rd_stb,
	output logic [ZPH_DW-1:0]            rdata_ff,
	input  wire logic signed [15:0]      setpoint,
	input  wire logic signed [15:0]      process_value,
	input  wire logic signed [15:0]      manipulated_variable,
	input  wire logic                    internal_contact_input,
	input  wire logic                    motor_drive_relay_output,
	output logic [2:0]                   group_ff,
	output logic                         zone_active_ff,
	output logic                         heat_group_ff,
	output logic signed [15:0]           heat_mv_ff,
	output logic signed [15:0]           cool_mv_ff
);
	logic [1:0]          ctrl_method_ff;
	logic [1:0]          zone_select_setting_ff;
	logic signed [15:0]  zone_thr_ff [ZPH_ZONES];
	logic [15:0]         zone_hysteresis_ff;
	logic [2:0]          sp_group_ff;
	logic                heat_cool_enable_ff;
	logic                heat_cool_energy_mode_ff;
	zph_hc_cfg_t         hc_cfg_ff;
	logic [2:0]          zone_ff;
	logic                side_heat_ff;

	logic                zone_cfg_ok;
	logic                hc_cfg_ok;
	logic                zone_en;
	logic                hc_on;
	logic signed [17:0]  cmp_val;
	logic [2:0]          raw_zone;
	logic signed [17:0]  hys_x;
	logic signed [17:0]  up_thr;
	logic signed [17:0]  dn_thr;
	logic                zone_move;
	logic [2:0]          nxt_zone;
	logic signed [31:0]  mv2;
	logic signed [31:0]  cp2;
	logic signed [31:0]  db_x;
	logic signed [31:0]  den2;
	logic signed [31:0]  heat_raw;
	logic signed [31:0]  cool_raw;
	logic signed [31:0]  heat_in;
	logic signed [31:0]  cool_in;
	logic                suppress;
	logic                nxt_side_heat;
	logic signed [15:0]  heat_clamped;
	logic signed [15:0]  cool_clamped;
	logic [ZPH_DW-1:0]   nxt_rdata;

	assign zone_cfg_ok = (ctrl_method_ff == ZPH_CTRL_PIDFIX);
	assign hc_cfg_ok   = heat_cool_enable_ff;
	assign zone_en     = zone_cfg_ok && (zone_select_setting_ff != ZPH_ZSEL_OFF)
		&& !internal_contact_input;
	assign hc_on       = heat_cool_enable_ff && !motor_drive_relay_output;

	// configuration writes; hidden settings ignore writes
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctrl_method_ff           <= ZPH_RST_CTRL;
			zone_select_setting_ff   <= ZPH_ZSEL_OFF;
			zone_hysteresis_ff       <= ZPH_RST_ZHYS;
			sp_group_ff              <= 3'h0;
			heat_cool_enable_ff      <= 1'b0;
			heat_cool_energy_mode_ff <= 1'b0;
		end
		else if (wr_stb)
		begin
			case (addr)
				ZPH_A_CTRL:   ctrl_method_ff <= wdata[1:0];
				ZPH_A_SPGRP:  sp_group_ff <= wdata[2:0];
				ZPH_A_HCEN:   heat_cool_enable_ff <= wdata[0];
				ZPH_A_ZSEL:   if (zone_cfg_ok) zone_select_setting_ff <= wdata[1:0];
				ZPH_A_ZHYS:   if (zone_cfg_ok) zone_hysteresis_ff <= wdata;
				ZPH_A_HCMODE: if (hc_cfg_ok) heat_cool_energy_mode_ff <= wdata[0];
				default:      ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < ZPH_ZONES; i++)
				zone_thr_ff[i] <= ZPH_RST_ZONE;
		end
		else
		begin
			for (int i = 0; i < ZPH_ZONES; i++)
				if (wr_stb && zone_cfg_ok && addr == ZPH_A_ZONE0 + 5'(i))
					zone_thr_ff[i] <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			hc_cfg_ff.deadband     <= ZPH_RST_DB;
			hc_cfg_ff.change_point <= ZPH_RST_CP;
			hc_cfg_ff.heat_lim.lo  <= ZPH_RST_LO;
			hc_cfg_ff.heat_lim.hi  <= ZPH_RST_HI;
			hc_cfg_ff.cool_lim.lo  <= ZPH_RST_LO;
			hc_cfg_ff.cool_lim.hi  <= ZPH_RST_HI;
		end
		else if (wr_stb)
		begin
			case (addr)
				ZPH_A_DB:   if (hc_cfg_ok) hc_cfg_ff.deadband <= wdata;
				ZPH_A_CP:   if (hc_cfg_ok) hc_cfg_ff.change_point <= wdata;
				ZPH_A_MVLO: hc_cfg_ff.heat_lim.lo <= wdata;
				ZPH_A_MVHI: hc_cfg_ff.heat_lim.hi <= wdata;
				ZPH_A_CLLO: if (hc_cfg_ok) hc_cfg_ff.cool_lim.lo <= wdata;
				ZPH_A_CLHI: if (hc_cfg_ok) hc_cfg_ff.cool_lim.hi <= wdata;
				default:    ;
			endcase
		end
	end

	// zone search and hysteresis on leaving the current zone
	always_comb
	begin
		cmp_val = (zone_select_setting_ff == ZPH_ZSEL_SP) ? 18'(setpoint)
			: 18'(process_value);
		raw_zone = ZPH_LAST_GROUP;
		for (int i = ZPH_ZONES - 1; i >= 0; i--)
			if (cmp_val < 18'(zone_thr_ff[i]) + $signed(ZPH_ONE_UNIT))
				raw_zone = 3'(i);
		hys_x  = 18'(zone_hysteresis_ff);
		up_thr = (zone_ff < ZPH_LAST_GROUP) ? 18'(zone_thr_ff[zone_ff]) : 18'h1FFFF;
		dn_thr = (zone_ff != 3'h0) ? 18'(zone_thr_ff[zone_ff - 3'h1]) : 18'h20000;
		if (raw_zone > zone_ff)
			zone_move = cmp_val > up_thr + hys_x;
		else if (raw_zone < zone_ff)
			zone_move = cmp_val < dn_thr + $signed(ZPH_ONE_UNIT) - hys_x;
		else
			zone_move = 1'b0;
		if (!zone_en || zone_move)
			nxt_zone = raw_zone;
		else
			nxt_zone = zone_ff;
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			zone_ff        <= 3'h0;
			group_ff       <= 3'h0;
			zone_active_ff <= 1'b0;
		end
		else
		begin
			zone_ff        <= nxt_zone;
			zone_active_ff <= zone_en;
			group_ff       <= zone_en ? nxt_zone : sp_group_ff;
		end
	end

	// heat/cool arithmetic in doubled units so half the deadband stays exact
	always_comb
	begin
		mv2  = 32'(manipulated_variable) <<< 1;
		cp2  = 32'(hc_cfg_ff.change_point) <<< 1;
		db_x = 32'(hc_cfg_ff.deadband);
		den2 = cp2 - db_x;
		if (den2 == 32'h0)
		begin
			heat_raw = 32'h0;
			cool_raw = 32'h0;
		end
		else
		begin
			heat_raw = ((mv2 - cp2 - db_x) * $signed(ZPH_PCT_FULL)) / den2;
			cool_raw = ((cp2 - mv2 - db_x) * $signed(ZPH_PCT_FULL)) / den2;
		end
		suppress = heat_cool_energy_mode_ff && !hc_cfg_ff.deadband[15];
		if (mv2 >= cp2 + db_x)
			nxt_side_heat = 1'b1;
		else if (mv2 < cp2 - db_x)
			nxt_side_heat = 1'b0;
		else
			nxt_side_heat = side_heat_ff;
		if (!hc_on)
		begin
			heat_in = 32'(manipulated_variable);
			cool_in = 32'h0;
		end
		else if (suppress)
		begin
			heat_in = side_heat_ff ? heat_raw : 32'h0;
			cool_in = side_heat_ff ? 32'h0 : cool_raw;
		end
		else
		begin
			heat_in = heat_raw;
			cool_in = cool_raw;
		end
	end

	zph_clamp #(.W(32)) u_heat_clamp
	(
		.value  (heat_in),
		.lim    (hc_cfg_ff.heat_lim),
		.result (heat_clamped)
	);

	zph_clamp #(.W(32)) u_cool_clamp
	(
		.value  (cool_in),
		.lim    (hc_cfg_ff.cool_lim),
		.result (cool_clamped)
	);

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			heat_mv_ff    <= 16'h0000;
			cool_mv_ff    <= 16'h0000;
			heat_group_ff <= 1'b1;
			side_heat_ff  <= 1'b1;
		end
		else
		begin
			heat_mv_ff    <= heat_clamped;
			cool_mv_ff    <= hc_on ? cool_clamped : 16'h0000;
			heat_group_ff <= manipulated_variable >= $signed(ZPH_MV_HALF);
			side_heat_ff  <= nxt_side_heat;
		end
	end

	// read port; hidden settings read as zero
	always_comb
	begin
		case (addr)
			ZPH_A_CTRL:   nxt_rdata = 16'(ctrl_method_ff);
			ZPH_A_ZSEL:   nxt_rdata = zone_cfg_ok ? 16'(zone_select_setting_ff) : 16'h0000;
			ZPH_A_ZHYS:   nxt_rdata = zone_cfg_ok ? zone_hysteresis_ff : 16'h0000;
			ZPH_A_SPGRP:  nxt_rdata = 16'(sp_group_ff);
			ZPH_A_HCEN:   nxt_rdata = 16'(heat_cool_enable_ff);
			ZPH_A_HCMODE: nxt_rdata = hc_cfg_ok ? 16'(heat_cool_energy_mode_ff) : 16'h0000;
			ZPH_A_DB:     nxt_rdata = hc_cfg_ok ? hc_cfg_ff.deadband : 16'h0000;
			ZPH_A_CP:     nxt_rdata = hc_cfg_ok ? hc_cfg_ff.change_point : 16'h0000;
			ZPH_A_MVLO:   nxt_rdata = hc_cfg_ff.heat_lim.lo;
			ZPH_A_MVHI:   nxt_rdata = hc_cfg_ff.heat_lim.hi;
			ZPH_A_CLLO:   nxt_rdata = hc_cfg_ok ? hc_cfg_ff.cool_lim.lo : 16'h0000;
			ZPH_A_CLHI:   nxt_rdata = hc_cfg_ok ? hc_cfg_ff.cool_lim.hi : 16'h0000;
			ZPH_A_STAT:   nxt_rdata = {9'h000, side_heat_ff, heat_group_ff, zone_active_ff,
				1'b0, group_ff};
			ZPH_A_HEATMV: nxt_rdata = heat_mv_ff;
			ZPH_A_COOLMV: nxt_rdata = cool_mv_ff;
			default:
			begin
				nxt_rdata = 16'h0000;
				for (int i = 0; i < ZPH_ZONES; i++)
					if (addr == ZPH_A_ZONE0 + 5'(i) && zone_cfg_ok)
						nxt_rdata = zone_thr_ff[i];
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			rdata_ff <= 16'h0000;
		else
			rdata_ff <= rd_stb ? nxt_rdata : 16'h0000;
	end

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	property p_bank_group;
		!zone_en |=> group_ff == $past(sp_group_ff);
	endproperty
	a_bank_group: assert property (p_bank_group) else $error("bank group not used");

	property p_contact_off;
		internal_contact_input |=> !zone_active_ff && group_ff == $past(sp_group_ff);
	endproperty
	a_contact_off: assert property (p_contact_off) else $error("contact left zone on");

	property p_zone_locked;
		(wr_stb && addr == ZPH_A_ZONE0 && !zone_cfg_ok) |=> $stable(zone_thr_ff[0]);
	endproperty
	a_zone_locked: assert property (p_zone_locked) else $error("zone written off pid");

	property p_db_locked;
		(wr_stb && addr == ZPH_A_DB && !hc_cfg_ok) |=> $stable(hc_cfg_ff.deadband);
	endproperty
	a_db_locked: assert property (p_db_locked) else $error("deadband written hidden");

	property p_zone_hold;
		(zone_en && !zone_move) |=> zone_ff == $past(zone_ff) && group_ff == zone_ff;
	endproperty
	a_zone_hold: assert property (p_zone_hold) else $error("zone left inside hysteresis");

	property p_edge_unit;
		(cmp_val == 18'(zone_thr_ff[0])) |-> raw_zone == 3'h0;
	endproperty
	a_edge_unit: assert property (p_edge_unit) else $error("switched at threshold");

	property p_heat_group;
		1'b1 |=> heat_group_ff == ($past(manipulated_variable) >= $signed(ZPH_MV_HALF));
	endproperty
	a_heat_group: assert property (p_heat_group) else $error("group split not at half");

	property p_relay_cool;
		motor_drive_relay_output |=> cool_mv_ff == 16'h0000;
	endproperty
	a_relay_cool: assert property (p_relay_cool) else $error("cool out with relay");

	property p_heat_limits;
		(hc_cfg_ff.heat_lim.lo <= hc_cfg_ff.heat_lim.hi) |=>
			heat_mv_ff >= $past(hc_cfg_ff.heat_lim.lo) && heat_mv_ff <= $past(hc_cfg_ff.heat_lim.hi);
	endproperty
	a_heat_limits: assert property (p_heat_limits) else $error("heat mv out of limits");

	property p_swap;
		(hc_cfg_ff.cool_lim.lo > hc_cfg_ff.cool_lim.hi && hc_on) |=>
			cool_mv_ff <= $past(hc_cfg_ff.cool_lim.lo) && cool_mv_ff >= $past(hc_cfg_ff.cool_lim.hi);
	endproperty
	a_swap: assert property (p_swap) else $error("reversed limits not swapped");

	property p_energy;
		(hc_on && suppress && side_heat_ff && hc_cfg_ff.cool_lim.lo <= 16'h0000
			&& hc_cfg_ff.cool_lim.hi >= 16'h0000) |=> cool_mv_ff == 16'h0000;
	endproperty
	a_energy: assert property (p_energy) else $error("cool active in energy mode");

	c_zone_move: cover property (zone_en && zone_move);
	c_side_flip: cover property (hc_on && $rose(side_heat_ff));
	c_swap:      cover property (hc_cfg_ff.heat_lim.lo > hc_cfg_ff.heat_lim.hi);
	c_energy:    cover property (hc_on && suppress);
endmodule

// File: sim/zph_pid_model.sv
// behavioural stand-in for the pid core that feeds the manipulated variable
// assumes the bench names the next mv value; the core hands it over one edge later
`timescale 1ns/100ps
module zph_pid_model
	import zph_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               rstn,
	input  wire logic signed [15:0] mv_target,
	output logic signed [15:0]      mv_ff
);
	// the core result is registered, so the split sees it a cycle late
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			mv_ff <= 16'h0000;
		else
			mv_ff <= mv_target;
	end
endmodule

// File: sim/zph_top_bench.sv
// self-checking bench for the zone group selection and heat/cool split
// assumes the pid core model in zph_pid_model and the register map of zph_pkg
`timescale 1ns/100ps
module zph_top_bench
	import zph_pkg::*;
;
	logic               ref_clk;
	logic               rstn;
	logic [4:0]         addr;
	logic [15:0]        wdata;
	logic               wr_stb;
	logic               rd_stb;
	logic [15:0]        rdata_ff;
	logic signed [15:0] setpoint;
	logic signed [15:0] process_value;
	logic signed [15:0] mv_target;
	logic signed [15:0] mv;
	logic               contact;
	logic               relay;
	logic [2:0]         group_ff;
	logic               zone_active_ff;
	logic               heat_group_ff;
	logic signed [15:0] heat_mv_ff;
	logic signed [15:0] cool_mv_ff;
	logic [15:0]        rv;
	int                 error_cnt;
	int                 n_compared;

	zph_pid_model u_core (.ref_clk(ref_clk), .rstn(rstn), .mv_target(mv_target), .mv_ff(mv));
	zph_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff), .setpoint(setpoint),
		.process_value(process_value), .manipulated_variable(mv),
		.internal_contact_input(contact), .motor_drive_relay_output(relay),
		.group_ff(group_ff), .zone_active_ff(zone_active_ff), .heat_group_ff(heat_group_ff),
		.heat_mv_ff(heat_mv_ff), .cool_mv_ff(cool_mv_ff));

	always #20 ref_clk = ~ref_clk;

	task close_out();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe edge
	task rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		d = rdata_ff;
	endtask

	task mvset(input logic [15:0] v);
		@(posedge ref_clk);
		mv_target <= v;
		step(3);
	endtask

	task spset(input logic [15:0] v);
		@(posedge ref_clk);
		setpoint <= v;
		step(3);
	endtask

	// the zone jumps straight to the new group but only some cycles later, so poll with a bound
	task wait_grp(input logic [2:0] g);
		for (int i = 0; i < 50 && group_ff !== g; i++)
			step(1);
		chk("group", {13'h0000, group_ff}, {13'h0000, g});
		if (group_ff !== g)
			close_out();
	endtask

	initial
	begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		close_out();
	end

	initial
	begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		addr = 5'h00;
		wdata = 16'h0000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		setpoint = 16'h0032;
		process_value = 16'h0096;
		mv_target = 16'h0000;
		contact = 1'b0;
		relay = 1'b0;
		error_cnt = 0;
		n_compared = 0;
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		step(2);
		rd(ZPH_A_ZONE0, rv);
		chk("zone1", rv, 16'h270F);
		step(1);
		chk("rd idle", rdata_ff, 16'h0000);
		rd(ZPH_A_ZHYS, rv);
		chk("hyst", rv, 16'h0005);
		rd(ZPH_A_CTRL, rv);
		chk("ctrl", rv, 16'h0001);
		rd(5'h1F, rv);
		chk("unmapped", rv, 16'h0000);
		wr(ZPH_A_CP, 16'h02EE);
		wr(ZPH_A_DB, 16'h0064);
		rd(ZPH_A_CP, rv);
		chk("cp hidden", rv, 16'h0000);
		wr(ZPH_A_HCEN, 16'h0001);
		rd(ZPH_A_CP, rv);
		chk("cp shown", rv, 16'h01F4);
		// change point kept inside (0,100) and never at half the deadband
		wr(ZPH_A_CP, 16'h02EE);
		mvset(16'h03E8);
		chk("heat", heat_mv_ff, 16'h014D);
		chk("cool", cool_mv_ff, 16'h0000);
		rd(ZPH_A_HEATMV, rv);
		chk("heat reg", rv, 16'h014D);
		mvset(16'h01F4);
		chk("heat grp", {15'h0000, heat_group_ff}, 16'h0001);
		mvset(16'h01F3);
		chk("cool grp", {15'h0000, heat_group_ff}, 16'h0000);
		wr(ZPH_A_CP, 16'h01F4);
		wr(ZPH_A_DB, 16'h0064);
		mvset(16'h00FA);
		chk("cool db", cool_mv_ff, 16'h01BC);
		chk("heat lo", heat_mv_ff, 16'h0000);
		mvset(16'h0320);
		chk("heat db", heat_mv_ff, 16'h022B);
		wr(ZPH_A_DB, 16'h0000);
		wr(ZPH_A_MVLO, 16'h0320);
		wr(ZPH_A_MVHI, 16'h00C8);
		mvset(16'h03E8);
		chk("heat swap", heat_mv_ff, 16'h0320);
		wr(ZPH_A_MVLO, 16'h0000);
		wr(ZPH_A_MVHI, 16'h03E8);
		wr(ZPH_A_CLLO, 16'hFF9C);
		wr(ZPH_A_DB, 16'h00C8);
		mvset(16'h0320);
		chk("cool norm", cool_mv_ff, 16'hFF9C);
		chk("heat norm", heat_mv_ff, 16'h01F4);
		wr(ZPH_A_HCMODE, 16'h0001);
		step(2);
		chk("cool eco", cool_mv_ff, 16'h0000);
		mvset(16'h01C2);
		chk("cool eco band", cool_mv_ff, 16'h0000);
		mvset(16'h015E);
		chk("cool eco on", cool_mv_ff, 16'h007D);
		chk("heat eco off", heat_mv_ff, 16'h0000);
		mvset(16'h01C2);
		chk("cool eco hold", cool_mv_ff, 16'hFF9C);
		wr(ZPH_A_DB, 16'hFF9C);
		mvset(16'h0320);
		chk("heat neg db", heat_mv_ff, 16'h027C);
		chk("cool neg db", cool_mv_ff, 16'hFF9C);
		wr(ZPH_A_CLLO, 16'h00C8);
		wr(ZPH_A_CLHI, 16'h0032);
		step(2);
		chk("cool swap", cool_mv_ff, 16'h0032);
		@(posedge ref_clk);
		relay <= 1'b1;
		step(3);
		chk("cool relay", cool_mv_ff, 16'h0000);
		chk("heat relay", heat_mv_ff, 16'h0320);
		@(posedge ref_clk);
		relay <= 1'b0;
		wr(ZPH_A_HCEN, 16'h0000);
		mvset(16'h04B0);
		chk("heat plain", heat_mv_ff, 16'h03E8);
		chk("cool plain", cool_mv_ff, 16'h0000);
		wr(ZPH_A_SPGRP, 16'h0003);
		wr(ZPH_A_ZONE0, 16'h0064);
		wr(ZPH_A_ZONE0 + 5'h01, 16'h00C8);
		wr(ZPH_A_ZHYS, 16'h0000);
		wr(ZPH_A_ZSEL, 16'h0001);
		step(3);
		wait_grp(3'h0);
		chk("zone on", {15'h0000, zone_active_ff}, 16'h0001);
		spset(16'h0064);
		chk("at thr", {13'h0000, group_ff}, 16'h0000);
		spset(16'h0065);
		wait_grp(3'h1);
		wr(ZPH_A_ZHYS, 16'h0005);
		spset(16'h0060);
		chk("hys down", {13'h0000, group_ff}, 16'h0001);
		spset(16'h005F);
		wait_grp(3'h0);
		spset(16'h0069);
		chk("hys up", {13'h0000, group_ff}, 16'h0000);
		spset(16'h006A);
		wait_grp(3'h1);
		spset(16'h1388);
		wait_grp(3'h2);
		spset(16'h4E20);
		wait_grp(3'h7);
		wr(ZPH_A_ZSEL, 16'h0002);
		wait_grp(3'h1);
		@(posedge ref_clk);
		contact <= 1'b1;
		step(3);
		chk("contact", {15'h0000, zone_active_ff}, 16'h0000);
		wait_grp(3'h3);
		@(posedge ref_clk);
		contact <= 1'b0;
		wait_grp(3'h1);
		wr(ZPH_A_CTRL, 16'h0000);
		step(3);
		chk("method off", {15'h0000, zone_active_ff}, 16'h0000);
		rd(ZPH_A_ZSEL, rv);
		chk("zsel hidden", rv, 16'h0000);
		wr(ZPH_A_ZONE0, 16'h0001);
		wait_grp(3'h3);
		wr(ZPH_A_CTRL, 16'h0001);
		rd(ZPH_A_ZSEL, rv);
		chk("zsel shown", rv, 16'h0002);
		rd(ZPH_A_ZONE0, rv);
		chk("zone locked", rv, 16'h0064);
		@(posedge ref_clk);
		process_value <= 16'hFFF6;
		wait_grp(3'h0);
		wr(ZPH_A_ZSEL, 16'h0000);
		wait_grp(3'h3);
		chk("zone off", {15'h0000, zone_active_ff}, 16'h0000);
		close_out();
	end
endmodule
